//--- hdl/sacc_cfg.svh
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
// Operation
// - Convert rising edge starts hold and conversion
// - After conditioning, track again while quantizing
// - Results leave primary output in twos complement
// - Optional second output shares the busy pin
// - Two, four, six or eight channels sampled
// - Channel gains change only by configuration write
// - Four gain ranges, narrowest to widest
// - One 16-bit configuration word over serial link
// - Results held until end of next conversion
// - Conversion runs on internal clock only
// - Transfers happen only while chip select low
// - Asynchronous reset and separate power-down input
// - Two channels sustain 500 kSPS
// - Each channel converted relative to common input
// - Gain resets to widest code, others clear
// - Primary output data changes on serial clock falling
// - Chip select high shows busy on shared pin
// - Second output drives data after select falls

// Core clock rate
`define SACC_CLK_MHZ 200
// Phase times in ns, rounded up to whole cycles
`define SACC_COND_NS 500
`define SACC_QUANT_NS 300
`define SACC_COND_CYC ((`SACC_COND_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_QUANT_CYC ((`SACC_QUANT_NS * `SACC_CLK_MHZ + 999) / 1000)

// Configuration word fields
`define SACC_CFG_CH_HI 15
`define SACC_CFG_CH_LO 13
`define SACC_CFG_GAIN_HI 12
`define SACC_CFG_GAIN_LO 11
`define SACC_CFG_CNT_HI 10
`define SACC_CFG_CNT_LO 9
`define SACC_CFG_SECOND_SERIAL_OUT 8
`define SACC_CFG_LAST_BIT 8'h0F

// Reset values
`define SACC_GAIN_RST 2'h3
`define SACC_CNT_RST 2'h0
`define SACC_BIT_CNT_MAX 8'hFF
`endif

//--- hdl/sacc_pkg.sv
package sacc_pkg;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_COND  = 3'b010,
      S_QUANT = 3'b100
   } conv_state_t;

   // Core domain state
   typedef struct packed {
      conv_state_t      st;
      logic [7:0]       tmr;
      logic [2:0]       ch;
      logic [1:0]       ncode;
      logic [7:0][15:0] work;
      logic [7:0][15:0] res;
      logic [7:0][1:0]  gain;
      logic [1:0]       cnt_cfg;
      logic             second_serial_out_en;
      logic             hold;
      logic             busy;
      logic             pwr;
      logic             bo;
      logic [1:0]       cnv_s;
      logic             cnv_d;
      logic [1:0]       pd_s;
      logic [1:0]       cs_s;
      logic [1:0]       tgl_s;
      logic             tgl_d;
      logic [1:0]       sec_s;
   } core_t;

   // Link state ended by each frame
   typedef struct packed {
      logic [7:0]  cnt;
      logic [14:0] shin;
      logic        sdo1;
      logic        second_serial_out;
   } frame_t;

   // Link state kept across frames
   typedef struct packed {
      logic [15:0] cfg;
      logic        tgl;
   } keep_t;

endpackage

//--- hdl/sacc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sacc_cfg.svh"

module sacc_top (
   // Core clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Host control pins
   input  wire logic        convert_start,
   input  wire logic        power_down_input,
   // Serial link
   input  wire logic        ser_clk,
   input  wire logic        chip_select_n,
   input  wire logic        serial_cfg_in,
   output var  logic        primary_serial_out,
   output var  logic        busy_or_second_serial_out,
   // Front end quantizer
   input  wire logic [15:0] quant_pos,
   input  wire logic [15:0] quant_com,
   output var  logic        sample_hold,
   output var  logic [2:0]  quant_chan,
   output var  logic [15:0] gain_codes,
   // Status
   output var  logic        powered_down,
   output var  logic        conv_busy
);

   localparam logic [7:0] COND_CYC  = 8'(`SACC_COND_CYC);
   localparam logic [7:0] QUANT_CYC = 8'(`SACC_QUANT_CYC);

   localparam sacc_pkg::core_t CORE_RST = '{
      st      : sacc_pkg::S_IDLE,
      gain    : {8{`SACC_GAIN_RST}},
      cnt_cfg : `SACC_CNT_RST,
      ncode   : `SACC_CNT_RST,
      tgl_s   : 2'h0,
      default : '0
   };

   sacc_pkg::core_t  core_ff;
   sacc_pkg::core_t  nxt_core;
   sacc_pkg::frame_t frame_ff;
   sacc_pkg::frame_t nxt_frame;
   sacc_pkg::keep_t  keep_ff;
   sacc_pkg::keep_t  nxt_keep;

   logic             lk_rst;
   logic [3:0]       lk_nch;
   logic [3:0]       lk_words;

   // Saturating difference against the common input
   function automatic logic [15:0] diff_sat(
      input logic [15:0] p,
      input logic [15:0] c
   );
      logic [16:0] d;
      d = {p[15], p} - {c[15], c};
      if (d[16] != d[15]) begin
         diff_sat = d[16] ? 16'h8000 : 16'h7FFF;
      end else begin
         diff_sat = d[15:0];
      end
   endfunction

   // Enabled channel count from the two-bit code
   function automatic logic [3:0] chan_count(
      input logic [1:0] code
   );
      chan_count = 4'({code, 1'b0}) + 4'h2;
   endfunction

   // Bit of a lane at a given link bit count
   function automatic logic lane_bit(
      input logic [7:0][15:0] r,
      input logic [3:0]       first,
      input logic [3:0]       words,
      input logic [7:0]       cnt
   );
      logic [3:0] w;
      logic [3:0] b;
      logic [3:0] idx;
      w   = cnt[7:4];
      b   = 4'hF - cnt[3:0];
      idx = first + w;
      if (w < words) begin
         lane_bit = r[idx[2:0]][b];
      end else begin
         lane_bit = 1'b0;
      end
   endfunction

   // Core domain: conversion control on the internal clock
   always_comb begin
      nxt_core = core_ff;

      // Pin synchronisers
      nxt_core.cnv_s = {core_ff.cnv_s[0], convert_start};
      nxt_core.cnv_d = core_ff.cnv_s[1];
      nxt_core.pd_s  = {core_ff.pd_s[0], power_down_input};
      nxt_core.cs_s  = {core_ff.cs_s[0], chip_select_n};
      nxt_core.tgl_s = {core_ff.tgl_s[0], keep_ff.tgl};
      nxt_core.tgl_d = core_ff.tgl_s[1];
      nxt_core.sec_s = {core_ff.sec_s[0], frame_ff.second_serial_out};
      nxt_core.pwr   = core_ff.pd_s[1];

      // New configuration word; the held word is stable once the toggle lands
      if (core_ff.tgl_s[1] != core_ff.tgl_d) begin
         nxt_core.gain[keep_ff.cfg[`SACC_CFG_CH_HI:`SACC_CFG_CH_LO]] =
            keep_ff.cfg[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO];
         nxt_core.cnt_cfg = keep_ff.cfg[`SACC_CFG_CNT_HI:`SACC_CFG_CNT_LO];
         nxt_core.second_serial_out_en = keep_ff.cfg[`SACC_CFG_SECOND_SERIAL_OUT];
      end

      case (core_ff.st)
         sacc_pkg::S_IDLE: begin
            // Power-down blocks new conversions
            // Powered-down flag also blocks, so power-down leaves no start window
            if (core_ff.cnv_s[1] && !core_ff.cnv_d && !core_ff.pd_s[1] && !core_ff.pwr) begin
               nxt_core.st    = sacc_pkg::S_COND;
               nxt_core.hold  = 1'b1;
               nxt_core.busy  = 1'b1;
               nxt_core.ncode = core_ff.cnt_cfg;
               nxt_core.tmr   = COND_CYC - 8'h01;
            end
         end
         sacc_pkg::S_COND: begin
            // Edges here are dropped, not queued
            if (core_ff.tmr == 8'h00) begin
               nxt_core.st   = sacc_pkg::S_QUANT;
               nxt_core.hold = 1'b0;
               nxt_core.ch   = 3'h0;
               nxt_core.tmr  = QUANT_CYC - 8'h01;
            end else begin
               nxt_core.tmr = core_ff.tmr - 8'h01;
            end
         end
         sacc_pkg::S_QUANT: begin
            if (core_ff.tmr == 8'h00) begin
               nxt_core.work[core_ff.ch] = diff_sat(quant_pos, quant_com);
               if (core_ff.ch == 3'(chan_count(core_ff.ncode) - 4'h1)) begin
                  // Results replace the old set only at end of conversion
                  nxt_core.res  = nxt_core.work;
                  nxt_core.busy = 1'b0;
                  nxt_core.st   = sacc_pkg::S_IDLE;
               end else begin
                  nxt_core.ch  = core_ff.ch + 3'h1;
                  nxt_core.tmr = QUANT_CYC - 8'h01;
               end
            end else begin
               nxt_core.tmr = core_ff.tmr - 8'h01;
            end
         end
         default: begin
            nxt_core.st = sacc_pkg::S_IDLE;
         end
      endcase

      // Shared pin: busy unless selected with second lane on
      if (core_ff.cs_s[1] || !core_ff.second_serial_out_en) begin
         nxt_core.bo = core_ff.busy;
      end else begin
         nxt_core.bo = core_ff.sec_s[1];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_ff <= CORE_RST;
      end else begin
         core_ff <= nxt_core;
      end
   end

   // Link domain: the frame counter dies with chip select
   assign lk_rst   = rst | chip_select_n;
   assign lk_nch   = chan_count(core_ff.ncode);
   assign lk_words = core_ff.second_serial_out_en ? (lk_nch >> 1) : lk_nch;

   // Results are read quasi-static; valid only while not busy
   always_comb begin
      nxt_frame      = frame_ff;
      nxt_frame.shin = {frame_ff.shin[13:0], serial_cfg_in};
      if (frame_ff.cnt != `SACC_BIT_CNT_MAX) begin
         nxt_frame.cnt = frame_ff.cnt + 8'h01;
      end
      nxt_frame.sdo1 = lane_bit(core_ff.res, 4'h0, lk_words,
                                frame_ff.cnt);
      if (core_ff.second_serial_out_en) begin
         nxt_frame.second_serial_out = lane_bit(core_ff.res, lk_words, lk_words,
                                   frame_ff.cnt);
      end else begin
         nxt_frame.second_serial_out = 1'b0;
      end
   end

   always_ff @(negedge ser_clk or posedge lk_rst) begin
      if (lk_rst) begin
         frame_ff <= '0;
      end else begin
         frame_ff <= nxt_frame;
      end
   end

   // Sixteenth bit of a frame completes the configuration word
   always_comb begin
      nxt_keep = keep_ff;
      if (!chip_select_n && frame_ff.cnt == `SACC_CFG_LAST_BIT) begin
         nxt_keep.cfg = {frame_ff.shin, serial_cfg_in};
         nxt_keep.tgl = ~keep_ff.tgl;
      end
   end

   always_ff @(negedge ser_clk or posedge rst) begin
      if (rst) begin
         keep_ff <= '0;
      end else begin
         keep_ff <= nxt_keep;
      end
   end

   // Outputs straight from flip-flops
   assign primary_serial_out        = frame_ff.sdo1;
   assign busy_or_second_serial_out = core_ff.bo;
   assign sample_hold               = core_ff.hold;
   assign quant_chan                = core_ff.ch;
   assign gain_codes                = core_ff.gain;
   assign powered_down              = core_ff.pwr;
   assign conv_busy                 = core_ff.busy;

endmodule

`default_nettype wire

//--- dv/sacc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_checker (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Pins
   input wire logic       convert_start,
   input wire logic       chip_select_n,
   input wire logic       primary_serial_out,
   input wire logic       busy_or_second_serial_out,
   // Core status
   input wire logic       sample_hold,
   input wire logic [2:0] quant_chan,
   input wire logic       powered_down,
   input wire logic       conv_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [9:0] busy_cnt_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         busy_cnt_ff <= 10'h000;
      else
         busy_cnt_ff <= conv_busy ? busy_cnt_ff + 10'h001 : 10'h000;
   end
   chk_busy_pin: assert property ((chip_select_n && conv_busy) [*6] |-> busy_or_second_serial_out)
      else $error("busy pin low while converting");
   chk_start_hold: assert property ($rose(convert_start) && !conv_busy && !powered_down |-> ##[1:5] sample_hold)
      else $error("convert edge did not start hold");
   chk_hold_len: assert property ($rose(sample_hold) |-> ##99 sample_hold ##1 !sample_hold)
      else $error("hold phase length wrong");
   chk_track_chan: assert property ($fell(sample_hold) |-> conv_busy && quant_chan == 3'h0)
      else $error("track did not begin with first channel");
   chk_busy_len: assert property ($fell(conv_busy) |-> busy_cnt_ff inside {10'h0DC, 10'h154, 10'h1CC, 10'h244})
      else $error("busy length wrong");
   chk_chan_step: assert property (
      $changed(quant_chan) && conv_busy && $past(conv_busy) && !$past(sample_hold)
      |-> quant_chan == $past(quant_chan) + 3'h1) else $error("channel order wrong");
   chk_idle_out: assert property (chip_select_n |-> !primary_serial_out)
      else $error("data driven while deselected");
   chk_pd_block: assert property (powered_down [*3] ##0 !conv_busy |=> !conv_busy)
      else $error("conversion while powered down");
   cover property ($fell(conv_busy) && busy_cnt_ff == 10'h244);
   cover property (conv_busy && $rose(convert_start));
   cover property (powered_down && $rose(convert_start));
endmodule
bind sacc_top sacc_checker u_chk (.clk, .rst, .convert_start, .chip_select_n, .primary_serial_out,
   .busy_or_second_serial_out, .sample_hold, .quant_chan, .powered_down, .conv_busy);
`default_nettype wire

//--- dv/sacc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_host (
   // Link to device
   output logic      ser_clk,
   output logic      chip_select_n,
   output logic      serial_cfg_in,
   input wire logic  primary_serial_out,
   input wire logic  busy_or_second_serial_out
);
   // Clock stands high between frames
   initial begin
      ser_clk = 1'b1;
      chip_select_n = 1'b1;
      serial_cfg_in = 1'b0;
   end
   task automatic frame(input logic [15:0] cfg, input int nbits, output logic [143:0] rd1, output logic [143:0] rd2);
      rd1 = '0;
      rd2 = '0;
      chip_select_n = 1'b0;
      for (int k = 0; k < nbits; k++) begin
         serial_cfg_in = (k < 16) ? cfg[15 - k] : 1'b0;
         #62.5 ser_clk = 1'b0;
         #62.5 ser_clk = 1'b1;
         rd1 = {rd1[142:0], primary_serial_out};
         rd2 = {rd2[142:0], busy_or_second_serial_out};
      end
      #62.5 chip_select_n = 1'b1;
      serial_cfg_in = ~serial_cfg_in;
      // Deselected for a full period so the frame counter clears before the next frame
      #125;
   endtask
endmodule
`default_nettype wire

//--- dv/sacc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sacc_top_test;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         convert_start = 1'b0;
   logic         power_down_input = 1'b0;
   logic [15:0]  quant_pos = 16'h0000;
   logic [15:0]  quant_com = 16'h0000;
   logic         ser_clk, chip_select_n, serial_cfg_in, primary_serial_out, busy_or_second_serial_out;
   logic         sample_hold, powered_down, conv_busy;
   logic [2:0]   quant_chan;
   logic [15:0]  gain_codes;
   logic [15:0]  pos_tab [8] = '{default: 16'h0000};
   logic [15:0]  com_tab [8] = '{default: 16'h0000};
   logic [15:0]  exp_gain = 16'hFFFF;
   logic [143:0] rd1, rd2;
   int           num_errors = 0;
   int           check_count = 0;
   int           cycles = 0;
   always #2.5 clk = ~clk;
   sacc_top uut (.clk, .rst, .convert_start, .power_down_input, .ser_clk, .chip_select_n, .serial_cfg_in,
      .primary_serial_out, .busy_or_second_serial_out, .quant_pos, .quant_com, .sample_hold, .quant_chan,
      .gain_codes, .powered_down, .conv_busy);
   sacc_host host (.ser_clk, .chip_select_n, .serial_cfg_in, .primary_serial_out, .busy_or_second_serial_out);
   // Front end answers for the channel in its slot
   always @(posedge clk) begin
      #1;
      quant_pos = pos_tab[quant_chan];
      quant_com = com_tab[quant_chan];
      cycles++;
      if (cycles > 60000) begin
         num_errors++;
         end_sim();
      end
   end
   function automatic logic [15:0] sat(input logic [15:0] p, input logic [15:0] c);
      logic [16:0] d;
      d = {p[15], p} - {c[15], c};
      return (d[16] ^ d[15]) ? (d[16] ? 16'h8000 : 16'h7FFF) : d[15:0];
   endfunction
   // Words lo..hi-1 then one empty word
   function automatic logic [143:0] stream(input int lo, input int hi);
      logic [143:0] v;
      v = '0;
      for (int k = lo; k < hi; k++) v = {v[127:0], sat(pos_tab[k], com_tab[k])};
      return {v[127:0], 16'h0000};
   endfunction
   task automatic check(input string what, input logic [143:0] seen, input logic [143:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic convert();
      @(posedge clk) #1 convert_start = 1'b1;
      for (int i = 0; i < 8 && conv_busy !== 1'b1; i++) @(posedge clk);
      for (int i = 0; i < 700 && conv_busy !== 1'b0; i++) @(posedge clk);
      check("conversion end", 144'(conv_busy), 144'h0);
      @(posedge clk) #1 convert_start = 1'b0;
   endtask
   task automatic run(input logic [2:0] ch, input logic [1:0] g, input logic [1:0] cc, input logic l2);
      logic [15:0] cfg;
      int          n;
      int          m;
      cfg = {ch, g, cc, l2, 8'h00};
      n = 2 * (int'(cc) + 1);
      m = l2 ? n / 2 : n;
      host.frame(cfg, 16, rd1, rd2);
      exp_gain[2 * ch +: 2] = g;
      repeat (8) @(posedge clk);
      check("gain", 144'(gain_codes), 144'(exp_gain));
      foreach (pos_tab[k]) begin
         pos_tab[k] = 16'($urandom);
         com_tab[k] = 16'($urandom);
      end
      // Both saturation ends
      if (cc == 2'h3) begin
         pos_tab[0] = 16'h7FFF;
         com_tab[0] = 16'h8000;
         pos_tab[7] = 16'h8000;
         com_tab[7] = 16'h0001;
      end
      convert();
      repeat (2) begin
         host.frame(cfg, 16 * (m + 1), rd1, rd2);
         check("primary", rd1, stream(0, m));
         if (l2)
            check("second", rd2, stream(m, n));
      end
      $display("run cfg %h done", cfg);
   endtask
   initial begin
      void'($urandom(43971));
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      check("gain reset", 144'(gain_codes), 144'hFFFF);
      check("idle", 144'({conv_busy, sample_hold, powered_down}), 144'h0);
      @(posedge clk) #1 convert_start = 1'b1;
      repeat (40) @(posedge clk);
      #1 convert_start = 1'b0;
      repeat (20) @(posedge clk);
      #1 convert_start = 1'b1;
      repeat (190) @(posedge clk);
      check("edge while busy", 144'(conv_busy), 144'h0);
      #1 convert_start = 1'b0;
      power_down_input = 1'b1;
      repeat (6) @(posedge clk);
      #1 convert_start = 1'b1;
      repeat (10) @(posedge clk);
      check("power down", 144'({powered_down, conv_busy}), 144'h2);
      #1 convert_start = 1'b0;
      power_down_input = 1'b0;
      $display("control tests done");
      for (int i = 0; i < 4; i++) run(3'($urandom), 2'(i), 2'(i), 1'b0);
      run(3'h5, 2'h2, 2'h1, 1'b1);
      run(3'h2, 2'h0, 2'h3, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
